//--- verilog/ibtr_dev_end.sv
`default_nettype none
module ibtr_dev_end (
  input wire logic lclk,
  input wire logic srst,
  ibtr_link_if.dev link,
  input wire logic fast_mode,
  input wire logic go,
  input wire logic [ibtr_pkg::ADDR_W-1:0] peer_addr,
  output logic busy,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic nack_err
);
  import ibtr_pkg::*;

  typedef struct packed {
    logic [1:0] rst_sync;
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic scl_f;
    logic sda_f;
    logic [1:0] scl_fc;
    logic [1:0] sda_fc;
    ibtr_state_t state;
    logic [CNT_W-1:0] cnt;
    logic [BIT_W-1:0] bit_idx;
    logic fast;
    logic done;
    logic [7:0] tx;
    logic [7:0] rx;
    logic scl_oe;
    logic sda_oe;
    logic busy;
    logic rd_valid;
    logic nack_err;
    logic [7:0] rd_data;
  } ibtr_dev_st_t;

  localparam ibtr_dev_st_t DEV_RESET = '{
    rst_sync: 2'h0,
    scl_sync: 2'h3,
    sda_sync: 2'h3,
    scl_f: 1'b1,
    sda_f: 1'b1,
    scl_fc: 2'h0,
    sda_fc: 2'h0,
    state: IBTR_IDLE,
    cnt: 16'h0000,
    bit_idx: 5'h00,
    fast: 1'b0,
    done: 1'b0,
    tx: 8'h00,
    rx: 8'h00,
    scl_oe: 1'b0,
    sda_oe: 1'b0,
    busy: 1'b0,
    rd_valid: 1'b0,
    nack_err: 1'b0,
    rd_data: 8'h00
  };

  ibtr_dev_st_t st_reg;
  ibtr_dev_st_t st_next;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Filtered level follows input only after it stays changed past the limit
  function automatic logic [2:0] spike_filt(
    input logic s,
    input logic f,
    input logic [1:0] c,
    input logic [1:0] lim
  );
    logic [2:0] res;
    res = {f, 2'h0};
    if (s != f)
    begin
      if (c >= lim)
        res = {s, 2'h0};
      else
        res = {f, c + 2'h1};
    end
    return res;
  endfunction

  function automatic logic [CNT_W-1:0] low_cyc(input logic fast);
    return fast ? LOW_FS_CYC : LOW_STD_CYC;
  endfunction

  function automatic logic [CNT_W-1:0] high_cyc(input logic fast);
    return fast ? HIGH_FS_CYC : HIGH_STD_CYC;
  endfunction

  // Drive low for a zero address bit; release for ack, data and nack
  function automatic logic pull_sda(input logic [BIT_W-1:0] idx, input logic [7:0] tx);
    logic res;
    res = 1'b0;
    if (idx <= BIT_ADDR_LAST)
      res = ~tx[3'(BIT_ADDR_LAST - idx)];
    return res;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb
  begin
    logic [2:0] fr;
    fr = 3'h0;
    st_next = st_reg;
    st_next.rd_valid = 1'b0;
    st_next.rst_sync = {st_reg.rst_sync[0], ~link.rst_n};
    st_next.scl_sync = {st_reg.scl_sync[0], link.scl};
    st_next.sda_sync = {st_reg.sda_sync[0], link.sda};
    fr = spike_filt(st_reg.scl_sync[1], st_reg.scl_f, st_reg.scl_fc, SPIKE_SCL_CYC);
    st_next.scl_f = fr[2];
    st_next.scl_fc = fr[1:0];
    fr = spike_filt(st_reg.sda_sync[1], st_reg.sda_f, st_reg.sda_fc, SPIKE_SDA_CYC);
    st_next.sda_f = fr[2];
    st_next.sda_fc = fr[1:0];

    case (st_reg.state)
      IBTR_IDLE:
      begin
        st_next.scl_oe = 1'b0;
        st_next.sda_oe = 1'b0;
        st_next.cnt = '0;
        if (go)
        begin
          st_next.fast = fast_mode;
          st_next.tx = {peer_addr, 1'b1};
          st_next.busy = 1'b1;
          st_next.done = 1'b0;
          st_next.nack_err = 1'b0;
          st_next.state = IBTR_BUF;
        end
      end
      IBTR_BUF:
      begin
        // Idle bus must stay high for the free time before a new START
        if (!(st_reg.scl_f && st_reg.sda_f))
          st_next.cnt = '0;
        else if (st_reg.cnt >= (st_reg.fast ? BUF_FS_CYC : BUF_STD_CYC) - 16'h0001)
        begin
          st_next.cnt = '0;
          if (st_reg.done)
          begin
            st_next.busy = 1'b0;
            st_next.state = IBTR_IDLE;
          end
          else
          begin
            st_next.sda_oe = 1'b1;
            st_next.state = IBTR_START;
          end
        end
        else
          st_next.cnt = st_reg.cnt + 16'h0001;
      end
      IBTR_START:
      begin
        st_next.cnt = st_reg.cnt + 16'h0001;
        if (st_reg.cnt >= (st_reg.fast ? HD_STA_FS_CYC : HD_STA_STD_CYC) - 16'h0001)
        begin
          st_next.cnt = '0;
          st_next.bit_idx = '0;
          st_next.scl_oe = 1'b1;
          st_next.state = IBTR_LOW;
        end
      end
      IBTR_LOW:
      begin
        st_next.cnt = st_reg.cnt + 16'h0001;
        // New bit placed just after the fall, long before release
        if (st_reg.cnt == SDA_HOLD_CYC)
          st_next.sda_oe = pull_sda(st_reg.bit_idx, st_reg.tx);
        if (st_reg.cnt >= low_cyc(st_reg.fast) - 16'h0001)
        begin
          st_next.cnt = '0;
          st_next.scl_oe = 1'b0;
          st_next.state = IBTR_HIGH;
        end
      end
      IBTR_HIGH:
      begin
        // High time counts only once the line is seen high
        if (!st_reg.scl_f)
          st_next.cnt = '0;
        else if (st_reg.cnt >= high_cyc(st_reg.fast) - 16'h0001)
        begin
          st_next.cnt = '0;
          st_next.scl_oe = 1'b1;
          if (st_reg.bit_idx >= BIT_DATA_FIRST && st_reg.bit_idx <= BIT_DATA_LAST)
            st_next.rx = {st_reg.rx[6:0], st_reg.sda_f};
          if (st_reg.bit_idx == BIT_ACK && st_reg.sda_f)
          begin
            st_next.nack_err = 1'b1;
            st_next.state = IBTR_STOP_LO;
          end
          else if (st_reg.bit_idx == BIT_NACK)
            st_next.state = IBTR_STOP_LO;
          else
          begin
            st_next.bit_idx = st_reg.bit_idx + 5'h01;
            st_next.state = IBTR_LOW;
          end
        end
        else
          st_next.cnt = st_reg.cnt + 16'h0001;
      end
      IBTR_STOP_LO:
      begin
        st_next.cnt = st_reg.cnt + 16'h0001;
        if (st_reg.cnt == SDA_HOLD_CYC)
          st_next.sda_oe = 1'b1;
        if (st_reg.cnt >= low_cyc(st_reg.fast) - 16'h0001)
        begin
          st_next.cnt = '0;
          st_next.scl_oe = 1'b0;
          st_next.state = IBTR_STOP_HI;
        end
      end
      IBTR_STOP_HI:
      begin
        if (!st_reg.scl_f)
          st_next.cnt = '0;
        else if (st_reg.cnt >= (st_reg.fast ? SU_STO_FS_CYC : SU_STO_STD_CYC) - 16'h0001)
        begin
          st_next.cnt = '0;
          st_next.sda_oe = 1'b0;
          st_next.done = 1'b1;
          if (!st_reg.nack_err)
          begin
            st_next.rd_data = st_reg.rx;
            st_next.rd_valid = 1'b1;
          end
          st_next.state = IBTR_BUF;
        end
        else
          st_next.cnt = st_reg.cnt + 16'h0001;
      end
      default:
      begin
        st_next.state = IBTR_IDLE;
      end
    endcase

    // Reset pin: release both lines and abandon the frame
    if (st_reg.rst_sync[1])
    begin
      st_next.state = IBTR_IDLE;
      st_next.scl_oe = 1'b0;
      st_next.sda_oe = 1'b0;
      st_next.busy = 1'b0;
      st_next.cnt = '0;
    end
  end

  always_ff @(posedge lclk)
  begin
    if (srst)
      st_reg <= DEV_RESET;
    else
      st_reg <= st_next;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign link.dev_scl_o = 1'b0;
  assign link.dev_sda_o = 1'b0;
  assign link.dev_scl_oe = st_reg.scl_oe;
  assign link.dev_sda_oe = st_reg.sda_oe;
  assign busy = st_reg.busy;
  assign rd_data = st_reg.rd_data;
  assign rd_valid = st_reg.rd_valid;
  assign nack_err = st_reg.nack_err;
endmodule
`default_nettype wire

//--- shared/ibtr_pkg.sv
// Functional notes
// - Master clock never faster than 375 kHz
// - Hold after START before first clock
// - Clock low period minimum per mode
// - Clock high period minimum per mode
// - Clock high before repeated START
// - Clock high before STOP transition
// - Bus free time between STOP and START
// - Peer keeps data valid across both edges
// - Data setup met, bit before clock release
// - Reset pin held at least 200 ns
// - Outputs inactive within 100 us of reset
// - Input filters suppress clock and data spikes
`default_nettype none
package ibtr_pkg;
  ////////////////////////////////////////////////////////////////////////////
  // Clock rates
  localparam int LINK_PERIOD_NS = 64;
  localparam int SYS_PERIOD_NS = 10;

  function automatic int cyc_ceil(input int t_ns, input int per_ns);
    int c;
    c = (t_ns + per_ns - 1) / per_ns;
    return (c < 1) ? 1 : c;
  endfunction

  function automatic int imax(input int a, input int b);
    return (a > b) ? a : b;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Bus timing, nanoseconds; master rate in kHz, port wait in ms
  localparam int F_MASTER_MAX_KHZ = 375;
  localparam int T_HD_STA_STD_NS = 4000;
  localparam int T_HD_STA_FS_NS = 600;
  localparam int T_LOW_STD_NS = 4700;
  localparam int T_LOW_FS_NS = 1300;
  localparam int T_HIGH_STD_NS = 4000;
  localparam int T_HIGH_FS_NS = 600;
  localparam int T_SU_STA_STD_NS = 4700;
  localparam int T_SU_STA_FS_NS = 600;
  localparam int T_SU_STO_STD_NS = 4000;
  localparam int T_SU_STO_FS_NS = 600;
  localparam int T_BUF_STD_NS = 4700;
  localparam int T_BUF_FS_NS = 1300;
  localparam int T_SU_DAT_NS = 250;
  localparam int T_SPIKE_SCL_NS = 14;
  localparam int T_SPIKE_SDA_NS = 22;
  localparam int T_RST_MIN_NS = 200;
  localparam int T_PORT_WAIT_MS = 50;

  ////////////////////////////////////////////////////////////////////////////
  // Derived cycle counts
  localparam int CNT_W = 16;
  localparam int MST_PERIOD_CYC =
    (1_000_000 + F_MASTER_MAX_KHZ * LINK_PERIOD_NS - 1) / (F_MASTER_MAX_KHZ * LINK_PERIOD_NS);
  localparam logic [CNT_W-1:0] HD_STA_STD_CYC = CNT_W'(cyc_ceil(T_HD_STA_STD_NS, LINK_PERIOD_NS));
  localparam logic [CNT_W-1:0] HD_STA_FS_CYC = CNT_W'(cyc_ceil(T_HD_STA_FS_NS, LINK_PERIOD_NS));
  localparam logic [CNT_W-1:0] LOW_STD_CYC = CNT_W'(cyc_ceil(T_LOW_STD_NS, LINK_PERIOD_NS));
  localparam logic [CNT_W-1:0] LOW_FS_CYC = CNT_W'(cyc_ceil(T_LOW_FS_NS, LINK_PERIOD_NS));
  localparam logic [CNT_W-1:0] HIGH_STD_CYC = CNT_W'(imax(cyc_ceil(T_HIGH_STD_NS,
    LINK_PERIOD_NS), MST_PERIOD_CYC - int'(LOW_STD_CYC)));
  localparam logic [CNT_W-1:0] HIGH_FS_CYC = CNT_W'(imax(cyc_ceil(T_HIGH_FS_NS,
    LINK_PERIOD_NS), MST_PERIOD_CYC - int'(LOW_FS_CYC)));
  localparam logic [CNT_W-1:0] SU_STO_STD_CYC = CNT_W'(cyc_ceil(T_SU_STO_STD_NS, LINK_PERIOD_NS));
  localparam logic [CNT_W-1:0] SU_STO_FS_CYC = CNT_W'(cyc_ceil(T_SU_STO_FS_NS, LINK_PERIOD_NS));
  localparam logic [CNT_W-1:0] BUF_STD_CYC = CNT_W'(imax(cyc_ceil(T_BUF_STD_NS, LINK_PERIOD_NS),
    cyc_ceil(T_SU_STA_STD_NS, LINK_PERIOD_NS)));
  localparam logic [CNT_W-1:0] BUF_FS_CYC = CNT_W'(imax(cyc_ceil(T_BUF_FS_NS, LINK_PERIOD_NS),
    cyc_ceil(T_SU_STA_FS_NS, LINK_PERIOD_NS)));
  localparam logic [CNT_W-1:0] SU_DAT_CYC = CNT_W'(cyc_ceil(T_SU_DAT_NS, LINK_PERIOD_NS));
  localparam logic [CNT_W-1:0] SDA_HOLD_CYC = 16'h0001;
  localparam logic [1:0] SPIKE_SCL_CYC = 2'(cyc_ceil(T_SPIKE_SCL_NS, LINK_PERIOD_NS));
  localparam logic [1:0] SPIKE_SDA_CYC = 2'(cyc_ceil(T_SPIKE_SDA_NS, LINK_PERIOD_NS));
  localparam int RST_W = 5;
  localparam logic [RST_W-1:0] RST_CYC = RST_W'(cyc_ceil(T_RST_MIN_NS, SYS_PERIOD_NS));
  localparam int PORT_WAIT_CYC = T_PORT_WAIT_MS * 1_000_000 / SYS_PERIOD_NS;
  localparam int WAIT_W = 23;

  ////////////////////////////////////////////////////////////////////////////
  // Frame layout: address, ack, data, master nack
  localparam int ADDR_W = 7;
  localparam int BIT_W = 5;
  localparam logic [BIT_W-1:0] BIT_ADDR_LAST = 5'h07;
  localparam logic [BIT_W-1:0] BIT_ACK = 5'h08;
  localparam logic [BIT_W-1:0] BIT_DATA_FIRST = 5'h09;
  localparam logic [BIT_W-1:0] BIT_DATA_LAST = 5'h10;
  localparam logic [BIT_W-1:0] BIT_NACK = 5'h11;

  typedef enum logic [2:0] {
    IBTR_IDLE = 3'h0,
    IBTR_BUF = 3'h1,
    IBTR_START = 3'h3,
    IBTR_LOW = 3'h2,
    IBTR_HIGH = 3'h6,
    IBTR_STOP_LO = 3'h7,
    IBTR_STOP_HI = 3'h5
  } ibtr_state_t;
endpackage
`default_nettype wire

//--- shared/ibtr_link_if.sv
`default_nettype none
interface ibtr_link_if;
  logic dev_scl_o;
  logic dev_scl_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic rst_n;
  logic scl;
  logic sda;

  // Open-drain wired-AND with pullups
  assign scl = ~((dev_scl_oe & ~dev_scl_o) | (host_scl_oe & ~host_scl_o));
  assign sda = ~((dev_sda_oe & ~dev_sda_o) | (host_sda_oe & ~host_sda_o));

  modport dev (
    output dev_scl_o,
    output dev_scl_oe,
    output dev_sda_o,
    output dev_sda_oe,
    input scl,
    input sda,
    input rst_n
  );

  modport host (
    output host_scl_o,
    output host_scl_oe,
    output host_sda_o,
    output host_sda_oe,
    output rst_n,
    input scl,
    input sda
  );
endinterface
`default_nettype wire

//--- verilog/ibtr_host_end.sv
`default_nettype none
module ibtr_host_end #(
  parameter int WAIT_CYC = ibtr_pkg::PORT_WAIT_CYC,
  parameter logic [ibtr_pkg::ADDR_W-1:0] SLAVE_ADDR = 7'h2A
) (
  input wire logic clk,
  input wire logic srst,
  ibtr_link_if.host link,
  input wire logic rst_req,
  input wire logic [7:0] mem_byte,
  output logic port_ready,
  output logic addressed,
  output logic sent
);
  import ibtr_pkg::*;

  typedef struct packed {
    logic [RST_W-1:0] rst_cnt;
    logic rst_drive;
    logic [WAIT_W-1:0] wait_cnt;
    logic ready;
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic scl_d;
    logic sda_d;
    logic active;
    logic rw;
    logic [BIT_W-1:0] idx;
    logic [7:0] sh;
    logic [7:0] tx;
    logic sda_oe;
    logic addressed;
    logic sent;
  } ibtr_host_st_t;

  localparam ibtr_host_st_t HOST_RESET = '{
    rst_cnt: RST_CYC,
    rst_drive: 1'b1,
    wait_cnt: 23'h00_0000,
    ready: 1'b0,
    scl_sync: 2'h3,
    sda_sync: 2'h3,
    scl_d: 1'b1,
    sda_d: 1'b1,
    active: 1'b0,
    rw: 1'b0,
    idx: 5'h00,
    sh: 8'h00,
    tx: 8'h00,
    sda_oe: 1'b0,
    addressed: 1'b0,
    sent: 1'b0
  };

  ibtr_host_st_t st_reg;
  ibtr_host_st_t st_next;

  always_comb
  begin
    logic scl;
    logic sda;
    logic [7:0] byte_in;
    scl = st_reg.scl_sync[1];
    sda = st_reg.sda_sync[1];
    byte_in = {st_reg.sh[6:0], sda};
    st_next = st_reg;
    st_next.addressed = 1'b0;
    st_next.sent = 1'b0;
    st_next.scl_sync = {st_reg.scl_sync[0], link.scl};
    st_next.sda_sync = {st_reg.sda_sync[0], link.sda};
    st_next.scl_d = scl;
    st_next.sda_d = sda;

    // Device reset pulse, then the wait before the port may be used
    if (rst_req)
    begin
      st_next.rst_cnt = RST_CYC;
      st_next.rst_drive = 1'b1;
      st_next.ready = 1'b0;
    end
    else if (st_reg.rst_drive)
    begin
      st_next.rst_cnt = st_reg.rst_cnt - 5'h01;
      if (st_reg.rst_cnt <= 5'h01)
      begin
        st_next.rst_drive = 1'b0;
        st_next.wait_cnt = '0;
      end
    end
    else if (!st_reg.ready)
    begin
      st_next.wait_cnt = st_reg.wait_cnt + 23'h00_0001;
      if (st_reg.wait_cnt >= WAIT_W'(WAIT_CYC - 1))
        st_next.ready = 1'b1;
    end

    // Serial memory slave
    if (scl && st_reg.scl_d && st_reg.sda_d && !sda)
    begin
      st_next.active = 1'b1;
      st_next.idx = '0;
      st_next.sda_oe = 1'b0;
    end
    else if (scl && st_reg.scl_d && !st_reg.sda_d && sda)
    begin
      st_next.active = 1'b0;
      st_next.sda_oe = 1'b0;
    end
    else if (st_reg.active && scl && !st_reg.scl_d)
    begin
      st_next.idx = st_reg.idx + 5'h01;
      if (st_reg.idx <= BIT_ADDR_LAST)
        st_next.sh = byte_in;
      if (st_reg.idx == BIT_ADDR_LAST)
      begin
        st_next.rw = byte_in[0];
        st_next.tx = mem_byte;
        if (byte_in[7:1] == SLAVE_ADDR)
          st_next.addressed = 1'b1;
        else
          st_next.active = 1'b0;
      end
      if (st_reg.idx == BIT_NACK || (st_reg.idx == BIT_ACK && !st_reg.rw))
      begin
        st_next.active = 1'b0;
        st_next.sent = st_reg.rw;
      end
    end
    else if (st_reg.active && !scl && st_reg.scl_d)
    begin
      // Data changes only after the low level is seen
      st_next.sda_oe = 1'b0;
      if (st_reg.idx == BIT_ACK)
        st_next.sda_oe = 1'b1;
      else if (st_reg.rw && st_reg.idx >= BIT_DATA_FIRST && st_reg.idx <= BIT_DATA_LAST)
        st_next.sda_oe = ~st_reg.tx[3'(BIT_DATA_LAST - st_reg.idx)];
    end
    else if (!st_reg.active && st_reg.scl_d && !scl)
      st_next.sda_oe = 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      st_reg <= HOST_RESET;
    else
      st_reg <= st_next;
  end

  // Clock never stretched
  assign link.host_scl_o = 1'b0;
  assign link.host_scl_oe = 1'b0;
  assign link.host_sda_o = 1'b0;
  assign link.host_sda_oe = st_reg.sda_oe;
  assign link.rst_n = ~st_reg.rst_drive;
  assign port_ready = st_reg.ready;
  assign addressed = st_reg.addressed;
  assign sent = st_reg.sent;
endmodule
`default_nettype wire

//--- tb/ibtr_link_checker.sv
`default_nettype none
module ibtr_link_checker (
  input wire logic lclk,
  input wire logic srst,
  input wire logic rst_n,
  input wire logic scl,
  input wire logic sda,
  input wire logic dev_scl_oe,
  input wire logic dev_sda_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PER_MIN = 42;
  localparam int LOW_MIN = 21;
  localparam int HIGH_MIN = 10;
  localparam int BUF_MIN = 21;
  localparam int STO_MIN = 10;
  localparam int SETUP_MIN = 4;
  logic [11:0] lo_reg, hi_reg, per_reg, free_reg, age_reg;
  logic [3:0] rhist_reg;
  logic quiet;

  function automatic logic [11:0] sat(input logic [11:0] v);
    return (v == 12'hFFF) ? v : v + 12'h001;
  endfunction

  // Timing checks paused around a link reset; the reset check stays on
  assign quiet = srst || !rst_n || (rhist_reg != 4'h0);

  always_ff @(posedge lclk)
  begin
    if (srst)
    begin
      lo_reg <= 12'h000;
      hi_reg <= 12'h000;
      per_reg <= 12'h000;
      free_reg <= 12'h000;
      age_reg <= 12'h000;
      rhist_reg <= 4'h0;
    end
    else
    begin
      lo_reg <= dev_scl_oe ? sat(lo_reg) : 12'h000;
      hi_reg <= scl ? sat(hi_reg) : 12'h000;
      per_reg <= $rose(dev_scl_oe) ? 12'h001 : sat(per_reg);
      free_reg <= (scl && sda) ? sat(free_reg) : 12'h000;
      age_reg <= $changed(sda) ? 12'h000 : sat(age_reg);
      rhist_reg <= {rhist_reg[2:0], !rst_n};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge lclk); endclocking
  default disable iff (quiet);

  a_master_period: assert property ($rose(dev_scl_oe) |-> per_reg >= PER_MIN)
    else $error("scl period below master limit");
  a_start_hold: assert property ($fell(sda) && scl |->
    !dev_scl_oe [*8] ##1 !dev_scl_oe [*2])
    else $error("first clock too soon after start");
  a_scl_low_min: assert property ($fell(dev_scl_oe) |-> lo_reg >= LOW_MIN)
    else $error("scl low period too short");
  a_scl_high_min: assert property ($rose(dev_scl_oe) |-> hi_reg >= HIGH_MIN)
    else $error("scl high period too short");
  a_stop_setup: assert property ($rose(sda) && scl |-> hi_reg >= STO_MIN)
    else $error("stop setup too short");
  a_bus_free: assert property ($fell(sda) && scl |-> free_reg >= BUF_MIN)
    else $error("bus free time too short");
  a_data_setup: assert property ($fell(dev_scl_oe) |-> age_reg >= SETUP_MIN)
    else $error("data setup before scl release too short");
  a_reset_quiet: assert property (disable iff (srst)
    rhist_reg[3] |-> !dev_scl_oe && !dev_sda_oe)
    else $error("outputs still active during reset");
endmodule
`default_nettype wire

//--- tb/i2c_bus_timing_and_reset_bench.sv
`default_nettype none
module i2c_bus_timing_and_reset_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import ibtr_pkg::*;
  localparam int WAIT_CYC = 200;
  localparam logic [6:0] SLAVE_ADDR = 7'h2A;
  logic clk = 1'h0;
  logic lclk = 1'h0;
  logic srst = 1'h1;
  logic lsrst = 1'h1;
  logic rst_req = 1'h0;
  logic fast_mode = 1'h0;
  logic go = 1'h0;
  logic [6:0] peer_addr = SLAVE_ADDR;
  logic [7:0] mem_byte = 8'h00;
  logic busy, rd_valid, nack_err, port_ready, addressed, sent, rst_n_mon;
  logic [7:0] rd_data;
  logic [7:0] rd_cnt = 8'h00;
  logic addr_seen = 1'h0;
  logic sent_seen = 1'h0;
  int errors = 0;
  int samples_checked = 0;

  ibtr_link_if link_if();
  assign rst_n_mon = link_if.rst_n;
  ibtr_dev_end ibtr_dev_end_inst (.lclk(lclk), .srst(lsrst), .link(link_if),
    .fast_mode(fast_mode), .go(go), .peer_addr(peer_addr), .busy(busy),
    .rd_data(rd_data), .rd_valid(rd_valid), .nack_err(nack_err));
  ibtr_host_end #(.WAIT_CYC(WAIT_CYC), .SLAVE_ADDR(SLAVE_ADDR)) ibtr_host_end_inst (
    .clk(clk), .srst(srst), .link(link_if), .rst_req(rst_req), .mem_byte(mem_byte),
    .port_ready(port_ready), .addressed(addressed), .sent(sent));
  ibtr_link_checker ibtr_link_checker_inst (.lclk(lclk), .srst(lsrst),
    .rst_n(link_if.rst_n), .scl(link_if.scl), .sda(link_if.sda),
    .dev_scl_oe(link_if.dev_scl_oe), .dev_sda_oe(link_if.dev_sda_oe));

  always #5 clk = ~clk;
  // Link clock off the system grid
  always
  begin
    if ($realtime == 0.0)
      #3.3;
    #32 lclk = ~lclk;
  end
  always @(posedge lclk)
    if (rd_valid === 1'h1) rd_cnt <= rd_cnt + 8'h01;
  always @(posedge clk)
  begin
    if (addressed === 1'h1) addr_seen <= 1'h1;
    if (sent === 1'h1) sent_seen <= 1'h1;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wait_for(input string what, input bit on_l, ref logic sig,
    input logic lvl, output int n);
    n = 0;
    while (sig !== lvl)
    begin
      if (on_l) @(negedge lclk);
      else @(negedge clk);
      n++;
      if (n > 20000)
      begin
        errors++;
        $display("[ERR] %s expected done seen timeout", what);
        tally_and_finish();
      end
    end
  endtask

  task automatic run_frame(input logic fm, input logic [6:0] pa, input logic [7:0] mb,
    output int n);
    @(negedge clk);
    mem_byte = mb;
    addr_seen = 1'h0;
    sent_seen = 1'h0;
    @(negedge lclk);
    rd_cnt = 8'h00;
    fast_mode = fm;
    peer_addr = pa;
    go = 1'h1;
    @(negedge lclk);
    go = 1'h0;
    wait_for("frame", 1'b1, busy, 1'h0, n);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_startup();
    int n;
    check("scl_oe", 8'(link_if.dev_scl_oe), 8'h00);
    check("sda_oe", 8'(link_if.dev_sda_oe), 8'h00);
    check("busy", 8'(busy), 8'h00);
    wait_for("ready", 1'b0, port_ready, 1'h1, n);
    check("ready_wait", 8'(n >= WAIT_CYC), 8'h01);
  endtask

  task automatic t_reads();
    logic [7:0] pat [4] = '{8'hA5, 8'h5A, 8'hFF, 8'h00};
    int n;
    for (int i = 0; i < 4; i++)
    begin
      run_frame(i[0], SLAVE_ADDR, pat[i], n);
      check("frame_len", 8'(n >= (i[0] ? 18 * 42 : 18 * (74 + 63))), 8'h01);
      check("rd_data", rd_data, pat[i]);
      check("rd_cnt", rd_cnt, 8'h01);
      check("nack_err", 8'(nack_err), 8'h00);
      check("addressed", 8'(addr_seen), 8'h01);
      check("sent", 8'(sent_seen), 8'h01);
    end
  endtask

  task automatic t_back2back();
    int n;
    @(negedge lclk);
    rd_cnt = 8'h00;
    fast_mode = 1'h1;
    peer_addr = SLAVE_ADDR;
    go = 1'h1;
    n = 0;
    while (rd_cnt < 8'h02 && n < 4000)
    begin
      @(negedge lclk);
      n++;
    end
    go = 1'h0;
    wait_for("b2b", 1'b1, busy, 1'h0, n);
    check("b2b_cnt", rd_cnt, 8'h02);
  endtask

  task automatic t_nack();
    int n;
    run_frame(1'h1, 7'h15, 8'h3C, n);
    check("nack_set", 8'(nack_err), 8'h01);
    check("nack_no_rd", rd_cnt, 8'h00);
    check("no_addr", 8'(addr_seen), 8'h00);
    run_frame(1'h1, SLAVE_ADDR, 8'hC3, n);
    check("nack_clr", 8'(nack_err), 8'h00);
    check("rd_after", rd_data, 8'hC3);
  endtask

  task automatic t_mid_reset();
    int n;
    @(negedge lclk);
    fast_mode = 1'h0;
    go = 1'h1;
    @(negedge lclk);
    go = 1'h0;
    repeat (300) @(negedge lclk);
    @(negedge clk);
    rst_req = 1'h1;
    @(negedge clk);
    rst_req = 1'h0;
    wait_for("rst_low", 1'b0, rst_n_mon, 1'h0, n);
    wait_for("rst_high", 1'b0, rst_n_mon, 1'h1, n);
    check("rst_width", 8'(n >= 20), 8'h01);
    check("ready_drop", 8'(port_ready), 8'h00);
    // Count the wait from the reset pin's release
    wait_for("ready2", 1'b0, port_ready, 1'h1, n);
    check("ready_wait2", 8'(n >= WAIT_CYC), 8'h01);
    @(negedge lclk);
    check("scl_oe_q", 8'(link_if.dev_scl_oe), 8'h00);
    check("sda_oe_q", 8'(link_if.dev_sda_oe), 8'h00);
    check("busy_q", 8'(busy), 8'h00);
    run_frame(1'h1, SLAVE_ADDR, 8'h96, n);
    check("rd_recover", rd_data, 8'h96);
  endtask

  initial
  begin
    repeat (6) @(negedge clk);
    srst = 1'h0;
    repeat (2) @(negedge lclk);
    lsrst = 1'h0;
    t_startup();
    t_reads();
    t_back2back();
    t_nack();
    t_mid_reset();
    tally_and_finish();
  end
endmodule
`default_nettype wire
